// *** hspc_far.sv ***
// Far side model: trigger pins and encoder counters
`default_nettype none
module hspc_far
(
  input  wire logic [hspc_pkg::UNITS-1:0]          trig_cmd,
  input  wire logic [hspc_pkg::POS_W-1:0]          enc_base,
  output logic [hspc_pkg::UNITS-1:0]               trig_in,
  output logic [hspc_pkg::UNITS*hspc_pkg::POS_W-1:0] enc_pos
);
  timeunit 1ns;
  timeprecision 1ns;
  import hspc_pkg::*;
  // Pins move off the clock edge, as an unsynchronised source would
  assign #7 trig_in = trig_cmd;
  // Distinct offset per encoder so a capture from the wrong unit shows
  always_comb
    for (int i = 0; i < UNITS; i++)
      enc_pos[i*POS_W +: POS_W] = enc_base + POS_W'(i);
endmodule
`default_nettype wire

// *** hspc_pkg.sv ***
// Package for the high-speed position capture block: register map, fields, modes, timing
`default_nettype none
package hspc_pkg;
  localparam int UNITS   = 8;
  localparam int POS_W   = 32;
  localparam int ADDR_W  = 8;
  localparam int BUF_D   = 16;
  localparam int BUF_AW  = 4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CFG    = 8'h00; // Per unit config, 8 words
  localparam logic [ADDR_W-1:0] OFF_ARM    = 8'h20; // Arm write: unit idx and value
  localparam logic [ADDR_W-1:0] OFF_STAT   = 8'h24; // Status flags
  localparam logic [ADDR_W-1:0] OFF_PSEL   = 8'h28; // Position read selector
  localparam logic [ADDR_W-1:0] OFF_POS    = 8'h2c; // Captured position of selected unit
  localparam logic [ADDR_W-1:0] OFF_BUFCNT = 8'h30; // Buffer fill level
  localparam logic [ADDR_W-1:0] OFF_BUFPOP = 8'h34; // Buffer read and pop
  localparam logic [ADDR_W-1:0] OFF_FEED   = 8'h38; // Analog feedback flags per unit

  // Config fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_MODE_W   = 3;
  localparam int CFG_BUF_BIT  = 3;
  localparam int CFG_CH_LSB   = 4;  // Upper nibble channel selector
  localparam logic [3:0] CH_PRIMARY   = 4'h0;
  localparam logic [3:0] CH_SECONDARY = 4'ha;
  // Arm fields
  localparam int ARM_UNIT_LSB = 0;
  localparam int ARM_VAL_BIT  = 8;

  localparam logic [7:0] CFG_RESET = 8'h00;

  // Timing: capture latency bound
  localparam int CLK_PERIOD_NS   = 40;
  localparam int LAT_MAX_NS      = 100;
  localparam int LAT_MAX_CYC     = LAT_MAX_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    HSPC_LVL_HI  = 3'b000,
    HSPC_LVL_LO  = 3'b001,
    HSPC_RISE    = 3'b010,
    HSPC_FALL    = 3'b011,
    HSPC_DIN     = 3'b100,
    HSPC_DIN_INV = 3'b101
  } hspc_mode_e;

  typedef struct packed {
    logic [3:0] chan;
    logic       buffered;
    hspc_mode_e mode;
  } hspc_cfg_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } hspc_bus_s;
endpackage
`default_nettype wire

// *** hspc_top.sv ***
// Eight-unit high-speed position capture with register port and capture buffer
// How it works
// - Each unit picks one of six trigger interpretations from its config register.
// - Non-inverting level: high trigger level is the capture condition.
// - Inverting level: low trigger level is the capture condition.
// - When armed and active, the encoder position is latched.
// - Single operation captures once then disarms itself.
// - Buffered operation pushes each position to a buffer and stays armed; only the lowest unit of simultaneous captures is pushed, none when full.
// - In level and edge settings the flag sticks once set until re-arm.
// - Plain-input settings make status follow the input, optionally inverted.
// - Arm commands and capture are ignored in plain-input settings.
// - Arm command carries a value; false disarms.
// - Capture latches within one clock after the synchronised trigger, well under 100 ns.
// - No capture on units flagged as analog feedback.
// - Every unit can capture while its encoder is in use, except in plain-input settings or when flagged as analog feedback.
// - Upper config nibble selects channel: 0x0 primary, 0xa secondary.
// - Single operation holds flag and position until re-arm.
// - Status read gives one flag per unit for eight units.
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`default_nettype none
module hspc_top
  import hspc_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   reset_n,
  input  wire logic [ADDR_W-1:0]      reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [31:0]                 reg_rdata,
  input  wire logic [UNITS-1:0]       trig_in,
  input  wire logic [UNITS*POS_W-1:0] enc_pos,
  output logic [UNITS-1:0]            status_out,
  output logic                        buf_overflow
);
  import hspc_pkg::*;

  hspc_cfg_s        cfg_ff [UNITS];
  logic [UNITS-1:0] analog_ff;
  logic [UNITS-1:0] trig_s1_ff;
  logic [UNITS-1:0] trig_s2_ff;
  logic [UNITS-1:0] unit_stat;
  logic [UNITS-1:0] unit_cap;
  logic [POS_W-1:0] unit_pos [UNITS];
  logic [2:0]       psel_ff;
  logic [31:0]      rdata_ff;
  logic [31:0]      nxt_rdata;
  logic [UNITS-1:0] status_ff;
  logic             ovf_ff;
  logic [POS_W-1:0] buf_mem [BUF_D];
  logic [BUF_AW-1:0] wp_ff;
  logic [BUF_AW-1:0] rp_ff;
  logic [BUF_AW:0]   cnt_ff;
  logic              push;
  logic              pop;
  logic [POS_W-1:0]  push_data;
  logic              arm_wr;
  logic [UNITS-1:0]  arm_sel;
  logic              wr_cfg;
  logic              wr_feed;
  logic              wr_psel;
  logic              wr_ovf_clr;
  logic              buf_full;
  logic              buf_empty;
  logic              accept;

  // Word decode shared by read and write paths
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // Config words sit at OFF_CFG + 4*unit
  function automatic logic cfg_hit(input logic [ADDR_W-1:0] a);
    cfg_hit = (a[ADDR_W-1:5] == OFF_CFG[ADDR_W-1:5]) && (a[1:0] == 2'b00);
  endfunction

  // Unit index of a config word address
  function automatic logic [2:0] unit_of(input logic [ADDR_W-1:0] a);
    unit_of = a[4:2];
  endfunction

  // Reserved trigger codes fall back to non-inverting level
  function automatic hspc_mode_e mode_of(input logic [31:0] w);
    logic [CFG_MODE_W-1:0] code;
    code = w[CFG_MODE_LSB +: CFG_MODE_W];
    if (code > 3'(HSPC_DIN_INV))
      mode_of = HSPC_LVL_HI;
    else
      mode_of = hspc_mode_e'(code);
  endfunction

  // Only the secondary code is kept, so a stray value never reads back
  function automatic logic [3:0] chan_of(input logic [31:0] w);
    if (w[CFG_CH_LSB +: 4] == CH_SECONDARY)
      chan_of = CH_SECONDARY;
    else
      chan_of = CH_PRIMARY;
  endfunction

  // Buffer pointers wrap at the buffer depth
  function automatic logic [BUF_AW-1:0] ptr_inc(input logic [BUF_AW-1:0] p);
    ptr_inc = p + 1'b1;
  endfunction

  // Write strobes decoded once for all register processes
  assign arm_wr     = reg_wr && hit(reg_addr, OFF_ARM);
  assign wr_cfg     = reg_wr && cfg_hit(reg_addr);
  assign wr_feed    = reg_wr && hit(reg_addr, OFF_FEED);
  assign wr_psel    = reg_wr && hit(reg_addr, OFF_PSEL);
  assign wr_ovf_clr = reg_wr && hit(reg_addr, OFF_BUFCNT);

  // One arm strobe per unit; the unit field picks exactly one
  always_comb
  begin
    arm_sel = '0;
    if (arm_wr)
      arm_sel[reg_wdata[ARM_UNIT_LSB +: 3]] = 1'b1;
  end

  // Two-flop synchroniser on the external triggers
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      trig_s1_ff <= '0;
      trig_s2_ff <= '0;
    end
    else
    begin
      trig_s1_ff <= trig_in;
      trig_s2_ff <= trig_s1_ff;
    end
  end

  // Config registers; unknown channel codes fall back to primary
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < UNITS; i++)
        cfg_ff[i] <= hspc_cfg_s'(CFG_RESET);
    end
    else if (wr_cfg)
    begin
      cfg_ff[unit_of(reg_addr)].mode     <= mode_of(reg_wdata);
      cfg_ff[unit_of(reg_addr)].buffered <= reg_wdata[CFG_BUF_BIT];
      cfg_ff[unit_of(reg_addr)].chan     <= chan_of(reg_wdata);
    end
  end

  // Analog feedback flags; a set bit keeps that unit from capturing
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      analog_ff <= '0;
    else if (wr_feed)
      analog_ff <= reg_wdata[UNITS-1:0];
  end

  // Selector for the captured position read
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      psel_ff <= 3'h0;
    else if (wr_psel)
      psel_ff <= reg_wdata[2:0];
  end

  // One unit per encoder, all running in parallel
  for (genvar g = 0; g < UNITS; g++)
  begin : g_unit
    hspc_unit u_unit (
      .sys_clk   (sys_clk),
      .reset_n   (reset_n),
      .cfg       (cfg_ff[g]),
      .analog_fb (analog_ff[g]),
      .trig_sync (trig_s2_ff[g]),
      .arm_wr    (arm_sel[g]),
      .arm_val   (reg_wdata[ARM_VAL_BIT]),
      .position  (enc_pos[g*POS_W +: POS_W]),
      .status    (unit_stat[g]),
      .capture   (unit_cap[g]),
      .cap_pos   (unit_pos[g])
    );
  end

  // Pick lowest buffered capturer; simultaneous ones from others are dropped
  always_comb
  begin
    push      = 1'b0;
    push_data = '0;
    for (int i = UNITS - 1; i >= 0; i--)
    begin
      if (unit_cap[i] && cfg_ff[i].buffered)
      begin
        push      = 1'b1;
        push_data = enc_pos[i*POS_W +: POS_W];
      end
    end
  end

  // Buffer state; a full buffer loses the push, an empty one refuses the pop
  assign buf_full  = (cnt_ff == (BUF_AW+1)'(BUF_D));
  assign buf_empty = (cnt_ff == '0);
  assign accept    = push && !buf_full;
  assign pop       = reg_rd && hit(reg_addr, OFF_BUFPOP) && !buf_empty;

  // Storage has no reset; words outside the fill count are never read
  always_ff @(posedge sys_clk)
  begin
    if (accept)
      buf_mem[wp_ff] <= push_data;
  end

  // Write pointer advances on each accepted capture
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      wp_ff <= '0;
    else if (accept)
      wp_ff <= ptr_inc(wp_ff);
  end

  // Read pointer advances on each pop
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      rp_ff <= '0;
    else if (pop)
      rp_ff <= ptr_inc(rp_ff);
  end

  // Fill count; an accepted push and a pop in one cycle leave it unchanged
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      cnt_ff <= '0;
    else
      cnt_ff <= cnt_ff + (BUF_AW+1)'(accept) - (BUF_AW+1)'(pop);
  end

  // Sticky overflow; set wins over a clearing write
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      ovf_ff <= 1'b0;
    else if (push && buf_full)
      ovf_ff <= 1'b1;
    else if (wr_ovf_clr)
      ovf_ff <= 1'b0;
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    nxt_rdata = 32'h0;
    if (cfg_hit(reg_addr))
      nxt_rdata[7:0] = cfg_ff[unit_of(reg_addr)];
    else if (hit(reg_addr, OFF_STAT))
      nxt_rdata[UNITS-1:0] = unit_stat;
    else if (hit(reg_addr, OFF_PSEL))
      nxt_rdata[2:0] = psel_ff;
    else if (hit(reg_addr, OFF_POS))
      nxt_rdata = unit_pos[psel_ff];
    else if (hit(reg_addr, OFF_BUFCNT))
      nxt_rdata = {15'h0, ovf_ff, 11'h0, cnt_ff};
    else if (hit(reg_addr, OFF_BUFPOP))
      nxt_rdata = buf_empty ? 32'h0 : buf_mem[rp_ff];
    else if (hit(reg_addr, OFF_FEED))
      nxt_rdata[UNITS-1:0] = analog_ff;
  end

  // Read data registered, valid only in the cycle after the strobe
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      rdata_ff <= 32'h0;
    else if (reg_rd)
      rdata_ff <= nxt_rdata;
    else
      rdata_ff <= 32'h0;
  end

  // Registered status pins
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      status_ff <= '0;
    else
      status_ff <= unit_stat;
  end

  assign reg_rdata    = rdata_ff;
  assign status_out   = status_ff;
  assign buf_overflow = ovf_ff;
endmodule
`default_nettype wire

// *** hspc_top_properties.sv ***
// Port-level checker for the eight-unit capture block
`default_nettype none
module hspc_top_props
(
  input wire logic                         sys_clk,
  input wire logic                         reset_n,
  input wire logic [hspc_pkg::ADDR_W-1:0]  reg_addr,
  input wire logic [31:0]                  reg_wdata,
  input wire logic                         reg_wr,
  input wire logic                         reg_rd,
  input wire logic [31:0]                  reg_rdata,
  input wire logic [hspc_pkg::UNITS-1:0]   trig_in,
  input wire logic [hspc_pkg::UNITS-1:0]   status_out,
  input wire logic                         buf_overflow
);
  timeunit 1ns;
  timeprecision 1ns;
  import hspc_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic [UNITS-1:0] plain_ff;
  logic [UNITS-1:0] inv_ff;
  logic [2:0]       recent_ff;
  logic             cfg_wr;
  assign cfg_wr = reg_wr && (reg_addr < OFF_ARM) && (reg_addr[1:0] == 2'b00);
  // Shadow of plain-input settings, where a flag may drop at any time
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      plain_ff <= '0;
      inv_ff <= '0;
    end
    else if (cfg_wr)
    begin
      plain_ff[reg_addr[4:2]] <= reg_wdata[2:1] == 2'b10;
      inv_ff[reg_addr[4:2]] <= reg_wdata[0];
    end
  end
  // Window of recent config or arm writes; only those may clear a flag
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      recent_ff <= '0;
    else
      recent_ff <= {recent_ff[1:0], cfg_wr || (reg_wr && reg_addr == OFF_ARM)};
  end
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside read slot");
  a_arm_reads_zero: assert property (reg_rd && reg_addr == OFF_ARM |=> reg_rdata == 32'h0)
    else $error("arm register read not zero");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h3c |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_stat_matches_out: assert property (reg_rd && reg_addr == OFF_STAT
    |=> reg_rdata == {24'h0, status_out}) else $error("status read differs");
  a_ovf_sticky: assert property (buf_overflow && !(reg_wr && reg_addr == OFF_BUFCNT)
    |=> buf_overflow) else $error("overflow dropped");
  a_ovf_reported: assert property (reg_rd && reg_addr == OFF_BUFCNT
    |=> reg_rdata[16] == $past(buf_overflow)) else $error("overflow bit wrong");
  a_flag_held: assert property (|(~status_out & $past(status_out) & ~plain_ff)
    |-> |recent_ff) else $error("flag fell without arming");
  a_plain_follows: assert property (($stable(trig_in[4]) && plain_ff[4]
    && $stable(inv_ff[4]))[*5] |-> status_out[4] == (trig_in[4] ^ inv_ff[4]))
    else $error("plain input not followed");
  c_pos_read: cover property (reg_rd && reg_addr == OFF_POS);
  c_overflow: cover property (buf_overflow);
  c_plain_high: cover property (plain_ff[4] && status_out[4]);
endmodule
bind hspc_top hspc_top_props u_props (.sys_clk(sys_clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .trig_in(trig_in), .status_out(status_out),
  .buf_overflow(buf_overflow));
`default_nettype wire

// *** hspc_unit.sv ***
// One capture unit: trigger detect, arming, status and captured position
`default_nettype none
module hspc_unit
  import hspc_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire hspc_cfg_s        cfg,
  input  wire logic             analog_fb,
  input  wire logic             trig_sync,
  input  wire logic             arm_wr,
  input  wire logic             arm_val,
  input  wire logic [POS_W-1:0] position,
  output logic                  status,
  output logic                  capture,
  output logic [POS_W-1:0]      cap_pos
);
  import hspc_pkg::*;

  logic             trig_d_ff;
  logic             armed_ff;
  logic             flag_ff;
  logic [POS_W-1:0] pos_ff;
  logic             plain;
  logic             active;

  // Plain-input settings bypass the capture path entirely
  assign plain = (cfg.mode == HSPC_DIN) || (cfg.mode == HSPC_DIN_INV);

  // Active condition for the selected interpretation
  always_comb
  begin
    case (cfg.mode)
      HSPC_LVL_HI: active = trig_sync;
      HSPC_LVL_LO: active = !trig_sync;
      HSPC_RISE:   active = trig_sync && !trig_d_ff;
      HSPC_FALL:   active = !trig_sync && trig_d_ff;
      default:     active = 1'b0;
    endcase
  end

  // Analog feedback axes never capture
  assign capture = armed_ff && active && !plain && !analog_fb;

  // Previous trigger level for edge detection
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      trig_d_ff <= 1'b0;
    else
      trig_d_ff <= trig_sync;
  end

  // Arming; single disarms on capture, buffered stays armed
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      armed_ff <= 1'b0;
    else if (arm_wr && !plain)
      armed_ff <= arm_val;
    else if (capture && !cfg.buffered)
      armed_ff <= 1'b0;
  end

  // Sticky flag; arming clears it, capture sets it
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      flag_ff <= 1'b0;
    else if (arm_wr && !plain && arm_val)
      flag_ff <= 1'b0;
    else if (capture)
      flag_ff <= 1'b1;
  end

  // Position latch held until next capture
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      pos_ff <= '0;
    else if (capture)
      pos_ff <= position;
  end

  // Plain settings show the live input, possibly inverted
  assign status  = plain ? (trig_sync ^ (cfg.mode == HSPC_DIN_INV)) : flag_ff;
  assign cap_pos = pos_ff;
endmodule
`default_nettype wire

// *** test_high_speed_position_capture.sv ***
// Self-checking bench for the eight-unit position capture block
`default_nettype none
module test_high_speed_position_capture;
  timeunit 1ns;
  timeprecision 1ns;
  import hspc_pkg::*;
  logic                   sys_clk = 1'b0;
  logic                   reset_n = 1'b0;
  logic [ADDR_W-1:0]      reg_addr = 8'h00;
  logic [31:0]            reg_wdata = 32'h0;
  logic                   reg_wr = 1'b0;
  logic                   reg_rd = 1'b0;
  logic [31:0]            reg_rdata;
  logic [UNITS-1:0]       trig_cmd = 8'h00;
  logic [POS_W-1:0]       enc_base = 32'h0;
  logic [UNITS-1:0]       trig_in;
  logic [UNITS*POS_W-1:0] enc_pos;
  logic [UNITS-1:0]       status_out;
  logic                   buf_overflow;
  logic [31:0]            d;
  logic [31:0]            cv [4] = '{32'ha5, 32'h58, 32'h06, 32'h0b};
  logic [31:0]            ce [4] = '{32'ha5, 32'h08, 32'h00, 32'h0b};
  int                     miscompares = 0;
  int                     checks = 0;

  // 25 MHz system clock
  always #20 sys_clk = ~sys_clk;

  hspc_top DUT (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .trig_in(trig_in), .enc_pos(enc_pos), .status_out(status_out),
    .buf_overflow(buf_overflow));
  hspc_far far (.trig_cmd(trig_cmd), .enc_base(enc_base), .trig_in(trig_in),
    .enc_pos(enc_pos));

  // A gap cycle after each strobe keeps one assignment per signal per step
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge sys_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(d, exp);
  endtask
  // Pin change, then enough cycles for sync and capture to finish
  task automatic trig(input int u, input logic v);
    trig_cmd[u] <= v;
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic wrap_up;
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 630 cycles
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    wrap_up;
  end

  // Main sequence
  initial
  begin
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rc(OFF_CFG, 32'h0);
    rc(OFF_STAT, 32'h0);
    rc(OFF_ARM, 32'h0);
    rc(8'h3c, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h1c, cv[i]);
      rc(8'h1c, ce[i]);
    end
    // Level and edge settings, one unit each; idle level is mode bit 0
    for (int m = 0; m < 4; m++)
    begin
      trig(m, m[0]);
      wr(OFF_CFG + 8'(4*m), 32'(m));
      wr(OFF_PSEL, 32'(m));
      enc_base <= 32'h1000 * (m + 1);
      wr(OFF_ARM, 32'h100 | m);
      rc(OFF_STAT, 32'h0);
      trig(m, !m[0]);
      rc(OFF_STAT, 32'h1 << m);
      rc(OFF_POS, 32'h1000 * (m + 1) + m);
      enc_base <= 32'h0;
      trig(m, m[0]);
      trig(m, !m[0]);
      rc(OFF_STAT, 32'h1 << m);
      rc(OFF_POS, 32'h1000 * (m + 1) + m);
      trig(m, m[0]);
      wr(OFF_ARM, 32'h100 | m);
      rc(OFF_STAT, 32'h0);
      wr(OFF_ARM, 32'(m));
      trig(m, !m[0]);
      rc(OFF_STAT, 32'h0);
      trig(m, m[0]);
    end
    // Plain input on unit 4, arm ignored there
    wr(OFF_CFG + 8'h10, 32'h4);
    trig(4, 1'b1);
    rc(OFF_STAT, 32'h10);
    chk(32'(status_out), 32'h10);
    wr(OFF_ARM, 32'h104);
    trig(4, 1'b0);
    rc(OFF_STAT, 32'h0);
    wr(OFF_PSEL, 32'h4);
    rc(OFF_POS, 32'h0);
    wr(OFF_CFG + 8'h10, 32'h5);
    trig(4, 1'b0);
    rc(OFF_STAT, 32'h10);
    wr(OFF_CFG + 8'h10, 32'h4);
    trig(4, 1'b0);
    // Analog feedback blocks capture on unit 5 until lifted
    wr(OFF_FEED, 32'h20);
    wr(OFF_ARM, 32'h105);
    trig(5, 1'b1);
    rc(OFF_STAT, 32'h0);
    wr(OFF_PSEL, 32'h5);
    rc(OFF_POS, 32'h0);
    trig(5, 1'b0);
    wr(OFF_FEED, 32'h0);
    trig(5, 1'b1);
    rc(OFF_STAT, 32'h20);
    trig(5, 1'b0);
    wr(OFF_ARM, 32'h105);
    // Buffered rising edges on unit 6: one arming, then fill past full
    wr(OFF_CFG + 8'h18, 32'ha);
    wr(OFF_ARM, 32'h106);
    for (int i = 0; i < 3; i++)
    begin
      enc_base <= 32'h200 * (i + 1);
      trig(6, 1'b1);
      trig(6, 1'b0);
    end
    rc(OFF_BUFCNT, 32'h3);
    for (int i = 0; i < 3; i++)
      rc(OFF_BUFPOP, 32'h200 * (i + 1) + 6);
    rc(OFF_BUFPOP, 32'h0);
    for (int i = 0; i < 17; i++)
    begin
      trig(6, 1'b1);
      trig(6, 1'b0);
    end
    rc(OFF_BUFCNT, 32'h10010);
    chk(32'(buf_overflow), 32'h1);
    wr(OFF_BUFCNT, 32'h0);
    rc(OFF_BUFCNT, 32'h10);
    wrap_up;
  end
endmodule
`default_nettype wire
